//--- hw/dsmc_regs.svh
`ifndef DSMC_REGS_SVH
`define DSMC_REGS_SVH
`define DSMC_AW             13
`define DSMC_EXT_BASE       13'h0100
`define DSMC_EXT_PAGE       5'h01
`define DSMC_OFF_CTRL       6'h00
`define DSMC_OFF_STATUS     6'h01
`define DSMC_OFF_ADDR       6'h02
`define DSMC_OFF_LENGTH     6'h03
`define DSMC_OFF_DATA       6'h04
`define DSMC_ID_ADDR        13'h1FF0
`define DSMC_CTRL_CRC       2
`define DSMC_CTRL_MEMORY_BUILT_IN_SELF_TEST     3
`define DSMC_ST_DONE        0
`define DSMC_ST_BUSY        1
`define DSMC_ST_FAIL        2
`define DSMC_BC_MSB         7
`define DSMC_BC_LSB         4
`define DSMC_CC_MSB         3
`define DSMC_CC_LSB         0
`define DSMC_BLOCK_COUNT    4'h0
// Arbitrary neutral continuation code.
`define DSMC_CONT_CODE      4'h5
`define DSMC_WORD0          32'h0000_0000
`define DSMC_LEN0           30'h0000_0000
`define DSMC_LEN1           30'h0000_0001
`define DSMC_STEP           32'h0000_0004
`define DSMC_CRC_POLY       32'hEDB8_8320
`define DSMC_FORCED_ADDR    32'h0000_0000
`define DSMC_FORCED_LEN     30'h0000_0400
`define DSMC_FORCED_SEED    32'hFFFF_FFFF
`endif

//--- hw/dsmc_pkg.sv
`default_nettype none
package dsmc_pkg;
  typedef enum logic [3:0] {
    DSMC_IDLE  = 4'b0001,
    DSMC_CRC   = 4'b0010,
    DSMC_MB_WR = 4'b0100,
    DSMC_MB_RD = 4'b1000
  } dsmc_state_type;

  // Shared setup of a memory service: start location, length in words, data.
  typedef struct packed {
    logic [31:0] addr;
    logic [29:0] len;
    logic [31:0] data;
  } dsmc_setup_type;
endpackage
`default_nettype wire

//--- hw/dsmc_top.sv
`include "dsmc_regs.svh"
`default_nettype none
module dsmc_top
  import dsmc_pkg::*;
#(
  parameter logic [31:0] FORCED_ADDR = `DSMC_FORCED_ADDR,
  parameter logic [29:0] FORCED_LEN  = `DSMC_FORCED_LEN,
  parameter logic [31:0] FORCED_SEED = `DSMC_FORCED_SEED
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 NRST,
  input  wire logic                 REG_REQ,
  input  wire logic                 REG_WRITE,
  input  wire logic [`DSMC_AW-1:0]  REG_ADDR,
  input  wire logic [31:0]          REG_WDATA,
  output var  logic [31:0]          REG_RDATA,
  output var  logic                 REG_ACK,
  output var  logic                 REG_ERR,
  input  wire logic                 REG_EXTERNAL,
  input  wire logic                 SECURITY_BIT,
  input  wire logic                 WRITE_PROTECT,
  output var  logic                 MEM_REQ,
  output var  logic                 MEM_WE,
  output var  logic [31:0]          MEM_ADDR,
  output var  logic [31:0]          MEM_WDATA,
  input  wire logic [31:0]          MEM_RDATA,
  input  wire logic                 MEM_ACK,
  output var  logic                 OP_DONE,
  output var  logic                 OP_FAIL
);

  // Word addressed memory walks need aligned start locations.
  if (FORCED_ADDR[1:0] != 2'b00) begin : g_bad_addr
    $error("FORCED_ADDR must be word aligned");
  end

  dsmc_state_type state;
  dsmc_state_type next_state;
  dsmc_setup_type setup;
  dsmc_setup_type run;
  logic [29:0]    remain;
  logic           done;
  logic           fail;
  logic           in_low;
  logic           sec_block;
  logic           reg_hit;
  logic [5:0]     word_off;
  logic           wr_ok;
  logic           launch;
  logic           launch_crc;
  logic           launch_mb;
  logic           last_word;
  logic           mem_take;
  logic [31:0]    crc_next;
  logic [31:0]    pattern;
  logic [31:0]    rd_value;

  function automatic logic [31:0] crc_word(input logic [31:0] crc, input logic [31:0] data);
    logic [31:0] c;
    c = crc ^ data;
    for (int i = 0; i < 32; i++) begin
      c = c[0] ? ((c >> 1) ^ `DSMC_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // The register set appears in the internal window and again in the first external page.
  assign in_low    = REG_ADDR < `DSMC_EXT_BASE;
  assign sec_block = REG_EXTERNAL && SECURITY_BIT && in_low;
  assign reg_hit   = in_low || (REG_ADDR[`DSMC_AW-1:8] == `DSMC_EXT_PAGE);
  assign word_off  = REG_ADDR[7:2];
  assign wr_ok     = REG_REQ && REG_WRITE && !sec_block && !WRITE_PROTECT;

  // Only an idle unit accepts a command; a write that lands mid-run is simply lost.
  assign launch     = wr_ok && reg_hit && (word_off == `DSMC_OFF_CTRL) && (state == DSMC_IDLE);
  assign launch_crc = launch && REG_WDATA[`DSMC_CTRL_CRC];
  assign launch_mb  = launch && !REG_WDATA[`DSMC_CTRL_CRC] && REG_WDATA[`DSMC_CTRL_MEMORY_BUILT_IN_SELF_TEST];

  assign mem_take  = MEM_REQ && MEM_ACK;
  assign last_word = remain == `DSMC_LEN1;
  assign crc_next  = crc_word(run.data, MEM_RDATA);
  assign pattern   = ~MEM_ADDR;

  always_comb begin
    next_state = state;
    case (state)
      DSMC_IDLE: begin
        if (launch_crc && (in_low ? setup.len : FORCED_LEN) != `DSMC_LEN0) begin
          next_state = DSMC_CRC;
        end else if (launch_mb && setup.len != `DSMC_LEN0) begin
          next_state = DSMC_MB_WR;
        end
      end
      DSMC_CRC: begin
        if (mem_take && last_word) begin
          next_state = DSMC_IDLE;
        end
      end
      DSMC_MB_WR: begin
        if (mem_take && last_word) begin
          next_state = DSMC_MB_RD;
        end
      end
      DSMC_MB_RD: begin
        if (mem_take && (last_word || MEM_RDATA != pattern)) begin
          next_state = DSMC_IDLE;
        end
      end
      default: next_state = DSMC_IDLE;
    endcase
  end

  // The unit runs whenever its clock does; there is no enable to wait for.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= DSMC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Running copies decouple the walk from later writes to the shared registers.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      run    <= '0;
      remain <= `DSMC_LEN0;
    end else if (launch_crc) begin
      if (in_low) begin
        run    <= setup;
        remain <= setup.len;
      end else begin
        run    <= '{addr: FORCED_ADDR, len: FORCED_LEN, data: FORCED_SEED};
        remain <= FORCED_LEN;
      end
    end else if (launch_mb) begin
      run    <= setup;
      remain <= setup.len;
    end else if (mem_take) begin
      if (state == DSMC_CRC) begin
        run.data <= crc_next;
      end
      if (state == DSMC_MB_WR && last_word) begin
        remain <= run.len;
      end else begin
        remain <= remain - `DSMC_LEN1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      MEM_REQ   <= 1'b0;
      MEM_WE    <= 1'b0;
      MEM_ADDR  <= `DSMC_WORD0;
      MEM_WDATA <= `DSMC_WORD0;
    end else begin
      // The request drops for one cycle after each acknowledge so every word is a fresh handshake.
      MEM_REQ <= (next_state != DSMC_IDLE) && !mem_take;
      MEM_WE  <= next_state == DSMC_MB_WR;
      if (launch_crc && !in_low) begin
        MEM_ADDR <= FORCED_ADDR;
      end else if (launch) begin
        MEM_ADDR <= setup.addr;
      end else if (mem_take && state == DSMC_MB_WR && last_word) begin
        MEM_ADDR <= run.addr;
      end else if (mem_take) begin
        MEM_ADDR <= MEM_ADDR + `DSMC_STEP;
      end
      if (launch_mb) begin
        MEM_WDATA <= ~setup.addr;
      end else if (mem_take) begin
        MEM_WDATA <= ~(MEM_ADDR + `DSMC_STEP);
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      if (launch) begin
        done <= 1'b0;
        fail <= 1'b0;
      end else if (state != DSMC_IDLE && next_state == DSMC_IDLE) begin
        done <= 1'b1;
        fail <= (state == DSMC_MB_RD) && (MEM_RDATA != pattern);
      end else if (launch == 1'b0 && state == DSMC_IDLE && next_state == DSMC_IDLE && done &&
                   wr_ok && reg_hit && word_off == `DSMC_OFF_STATUS && REG_WDATA[`DSMC_ST_DONE]) begin
        // Completion only happens while busy, so this clear can never hide a fresh completion.
        done <= 1'b0;
        fail <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      setup <= '0;
    end else begin
      if (wr_ok && reg_hit && word_off == `DSMC_OFF_ADDR) begin
        setup.addr <= {REG_WDATA[31:2], 2'b00};
      end
      if (wr_ok && reg_hit && word_off == `DSMC_OFF_LENGTH) begin
        setup.len <= REG_WDATA[31:2];
      end
      if (state == DSMC_CRC && next_state == DSMC_IDLE) begin
        setup.data <= crc_next;
      end else if (state == DSMC_MB_RD && next_state == DSMC_IDLE && MEM_RDATA != pattern) begin
        setup.data <= MEM_ADDR;
      end else if (wr_ok && reg_hit && word_off == `DSMC_OFF_DATA) begin
        setup.data <= REG_WDATA;
      end
    end
  end

  always_comb begin
    rd_value = `DSMC_WORD0;
    if (REG_ADDR == `DSMC_ID_ADDR) begin
      rd_value[`DSMC_BC_MSB:`DSMC_BC_LSB] = `DSMC_BLOCK_COUNT;
      rd_value[`DSMC_CC_MSB:`DSMC_CC_LSB] = `DSMC_CONT_CODE;
    end else if (reg_hit) begin
      case (word_off)
        `DSMC_OFF_STATUS: begin
          rd_value[`DSMC_ST_DONE] = done;
          rd_value[`DSMC_ST_BUSY] = state != DSMC_IDLE;
          rd_value[`DSMC_ST_FAIL] = fail;
        end
        `DSMC_OFF_ADDR:   rd_value = setup.addr;
        `DSMC_OFF_LENGTH: rd_value = {setup.len, 2'b00};
        `DSMC_OFF_DATA:   rd_value = setup.data;
        default:          rd_value = `DSMC_WORD0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_ACK   <= 1'b0;
      REG_ERR   <= 1'b0;
      REG_RDATA <= `DSMC_WORD0;
    end else begin
      REG_ACK   <= REG_REQ;
      REG_ERR   <= REG_REQ && (sec_block || (REG_WRITE && WRITE_PROTECT));
      REG_RDATA <= (REG_REQ && !REG_WRITE && !sec_block) ? rd_value : `DSMC_WORD0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      OP_DONE <= 1'b0;
      OP_FAIL <= 1'b0;
    end else begin
      OP_DONE <= done;
      OP_FAIL <= fail;
    end
  end

endmodule
`default_nettype wire

//--- verification/dsmc_checker.sv
`include "dsmc_regs.svh"
`default_nettype none
module dsmc_checker (
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        REG_REQ,
  input wire logic        REG_WRITE,
  input wire logic [12:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic        REG_ACK,
  input wire logic        REG_ERR,
  input wire logic        REG_EXTERNAL,
  input wire logic        SECURITY_BIT,
  input wire logic        WRITE_PROTECT,
  input wire logic        MEM_REQ,
  input wire logic        MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic        MEM_ACK,
  input wire logic        OP_DONE,
  input wire logic        OP_FAIL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_ack_follows_req: assert property (REG_REQ |=> REG_ACK) else $error("no ack");
  a_ack_has_cause: assert property (REG_ACK |-> $past(REG_REQ)) else $error("stray ack");
  a_secure_low_err: assert property (REG_REQ && REG_EXTERNAL && SECURITY_BIT && REG_ADDR < 13'h0100
    |=> REG_ERR && REG_RDATA == 32'h0) else $error("secured access not refused");
  a_cpu_never_err: assert property (REG_REQ && !REG_EXTERNAL && !(REG_WRITE && WRITE_PROTECT)
    |=> !REG_ERR) else $error("processor access refused");
  a_protect_write_err: assert property (REG_REQ && REG_WRITE && WRITE_PROTECT |=> REG_ERR)
    else $error("protected write accepted");
  a_id_read_value: assert property (REG_REQ && !REG_WRITE && (REG_ADDR >> 2) == (`DSMC_ID_ADDR >> 2)
    |=> REG_RDATA == {24'h0, `DSMC_BLOCK_COUNT, `DSMC_CONT_CODE}) else $error("identification value wrong");
  a_mem_req_held: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("memory request dropped early");
  a_mem_req_drop: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ) else $error("request kept after ack");
  a_fill_pattern: assert property (MEM_REQ && MEM_WE |-> MEM_WDATA == ~MEM_ADDR) else $error("fill pattern wrong");
  a_word_aligned: assert property (MEM_REQ |-> MEM_ADDR[1:0] == 2'h0) else $error("unaligned memory address");
  c_secure_err: cover property (REG_REQ && REG_EXTERNAL && SECURITY_BIT && REG_ADDR < 13'h0100);
  c_mem_write: cover property (MEM_REQ && MEM_WE && MEM_ACK);
  c_done_rise: cover property ($rose(OP_DONE));
  c_fail_rise: cover property ($rose(OP_FAIL));
endmodule
bind dsmc_top dsmc_checker chk_u (.*);
`default_nettype wire

//--- verification/dsmc_mem_model.sv
`default_nettype none
module dsmc_mem_model (
  input  wire logic        SYS_CLK,
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WE,
  input  wire logic [31:0] MEM_ADDR,
  input  wire logic [31:0] MEM_WDATA,
  input  wire logic        slow,
  input  wire logic        corrupt,
  output var  logic [31:0] MEM_RDATA,
  output var  logic        MEM_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  logic [31:0] junk = 32'h0;
  logic [1:0]  dly = 2'h0;
  initial for (int i = 0; i < 64; i++) mem[i] = 32'h9E37_79B9 * (i + 1);
  // Outside an ack the data lines churn, so a design that samples them late sees garbage.
  always @(posedge SYS_CLK) begin
    junk <= junk + 32'h1357_9BDF;
    MEM_ACK <= 1'b0;
    MEM_RDATA <= junk;
    if (MEM_REQ && MEM_ACK !== 1'b1) begin
      if (dly != 2'h0) dly <= dly - 2'h1;
      else begin
        MEM_ACK <= 1'b1;
        dly <= slow ? 2'h2 : 2'h0;
        if (MEM_WE) mem[MEM_ADDR[7:2]] <= MEM_WDATA;
        else MEM_RDATA <= mem[MEM_ADDR[7:2]] ^ {31'h0, corrupt};
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
`include "dsmc_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        SYS_CLK = 0, NRST = 0, REG_REQ = 0, REG_WRITE = 0, REG_EXTERNAL = 0, SECURITY_BIT = 0;
  logic        WRITE_PROTECT = 0, MEM_ACK, REG_ACK, REG_ERR, MEM_REQ, MEM_WE, OP_DONE, OP_FAIL, e;
  logic [12:0] REG_ADDR = 13'h0;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, r, a, s;
  logic        slow = 0, corrupt = 0;
  int          bad_count = 0, samples_checked = 0, cycles = 0, n;
  dsmc_top #(.FORCED_LEN(30'h4)) dut_u (.*);
  dsmc_mem_model mem_u (.*);
  always #12.5 SYS_CLK = ~SYS_CLK;
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The ceiling is dozens of times the expected run, so only a real hang trips it.
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(logic x, logic w, logic [12:0] ad, logic [31:0] d);
    @(negedge SYS_CLK);
    {REG_REQ, REG_WRITE, REG_EXTERNAL, REG_ADDR, REG_WDATA} = {1'b1, w, x, ad, d};
    // The answer stands only in the cycle after the taking edge, so it is read at the next falling edge.
    @(negedge SYS_CLK);
    REG_REQ = 0;
    chk(REG_ACK, 1);
    r = REG_RDATA;
    e = REG_ERR;
  endtask
  task automatic wait_done();
    repeat (400) begin
      @(posedge SYS_CLK);
      #1;
      if (OP_DONE === 1'b1) return;
    end
    chk(0, 1);
  endtask
  function automatic logic [31:0] crc(logic [31:0] c, logic [31:0] ad, int cnt);
    for (int k = 0; k < cnt; k++) begin
      c ^= mem_u.mem[(ad[7:2] + k) % 64];
      repeat (32) c = c[0] ? (c >> 1) ^ `DSMC_CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  initial begin
    void'($urandom(71));
    repeat (4) @(posedge SYS_CLK);
    @(negedge SYS_CLK) NRST = 1;
    acc(0, 1, `DSMC_ID_ADDR, 32'hFFFF_FFFF);
    acc(1, 0, `DSMC_ID_ADDR, 0);
    chk(r, {24'h0, `DSMC_BLOCK_COUNT, `DSMC_CONT_CODE});
    SECURITY_BIT = 1;
    acc(1, 0, 13'h008, 0);
    chk(e, 1);
    acc(0, 1, 13'h008, 32'h40);
    chk(e, 0);
    acc(1, 0, 13'h108, 0);
    chk(r, 32'h40);
    WRITE_PROTECT = 1;
    acc(0, 1, 13'h008, 32'h80);
    chk(e, 1);
    WRITE_PROTECT = 0;
    acc(0, 0, 13'h008, 0);
    chk(r, 32'h40);
    acc(0, 0, 13'h0800, 0);
    chk({r[30:0], e}, 0);
    for (int i = 0; i < 6; i++) begin
      slow = $urandom;
      a = $urandom & 32'hFC;
      s = $urandom;
      n = $urandom_range(1, 8);
      acc(0, 1, 13'h008, a);
      acc(0, 1, 13'h00C, n << 2);
      acc(0, 1, 13'h010, s);
      acc(i[0], 1, i[0] ? 13'h100 : 13'h000, 32'h4);
      acc(0, 1, 13'h000, 32'h8);
      wait_done();
      acc(0, 0, 13'h010, 0);
      chk(r, i[0] ? crc(32'hFFFF_FFFF, 0, 4) : crc(s, a, n));
      chk(OP_FAIL, 0);
    end
    for (int j = 0; j < 2; j++) begin
      corrupt = j[0];
      acc(0, 1, 13'h008, 0);
      acc(0, 1, 13'h00C, 32'h20);
      acc(0, 1, 13'h000, 32'h8);
      wait_done();
      chk(OP_FAIL, j);
    end
    acc(0, 0, 13'h010, 0);
    chk(r, 0);
    // The status word must show done and fail, and a write of one to done clears both while idle.
    acc(0, 0, 13'h004, 0);
    chk(r, (32'h1 << `DSMC_ST_DONE) | (32'h1 << `DSMC_ST_FAIL));
    acc(0, 1, 13'h004, 32'h1 << `DSMC_ST_DONE);
    acc(0, 0, 13'h004, 0);
    chk(r, 0);
    chk(OP_DONE, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
